// ===== rtl/adc_queue_pkg.sv
// Purpose: Shared constants and types for the two-queue converter scheduler.
// Assumes: One module clock; entries are held in flip-flops.
// Notes: Queue state codes pack queue 1 in the upper pair, queue 2 in the lower pair.
package adc_queue_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Table geometry and result width.
    localparam int TABLE_DEPTH = 64;
    localparam int IDX_W = 6;
    localparam int PTR_W = 7;
    localparam int CHAN_W = 6;
    localparam int RES_W = 10;
    localparam int STATE_W = 4;

    // Channel code that marks the end of a queue.
    localparam logic [CHAN_W-1:0] END_OF_QUEUE_CODE = 6'h3f;
    // First index past the table; queue 1 always starts at the table's first entry.
    localparam logic [PTR_W-1:0] TABLE_END = 7'h40;
    localparam logic [PTR_W-1:0] Q1_BEGIN = 7'h00;
    localparam logic [PTR_W-1:0] PTR_STEP = 7'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Two-bit per-queue codes inside the queue state field.
    localparam logic [1:0] ST1_IDLE = 2'h0;
    localparam logic [1:0] ST1_PAUSED = 2'h1;
    localparam logic [1:0] ST1_ACTIVE = 2'h2;
    localparam logic [1:0] ST2_IDLE = 2'h0;
    localparam logic [1:0] ST2_PAUSED = 2'h1;
    localparam logic [1:0] ST2_RUN_OR_SUSP = 2'h2;
    localparam logic [1:0] ST2_PENDING = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // One command table entry.
    typedef struct packed {
        logic pause;
        logic [CHAN_W-1:0] chan;
    } conversion_command_entry_t;

    // Per-queue operating mode.
    typedef struct packed {
        logic ext_rise_en;
        logic continuous;
        logic auto_loop;
    } queue_mode_t;

    // Per-queue sticky status flags.
    typedef struct packed {
        logic completion_flag;
        logic pause_flag;
        logic trigger_overrun_flag;
    } queue_flags_t;

    // Sequencing engine states.
    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_FETCH = 3'b010,
        ENG_CONV = 3'b100
    } engine_state_t;

    // Per-queue condition.
    typedef enum logic [3:0] {
        QST_IDLE = 4'b0001,
        QST_ACTIVE = 4'b0010,
        QST_PAUSED = 4'b0100,
        QST_SUSP = 4'b1000
    } queue_status_t;

endpackage

// ===== rtl/adc_queue_scheduler.sv
// Purpose: Sequences a 64-entry conversion table as two prioritised queues onto one converter.
// Assumes: Software, timer and converter strobes are on mclk; trigger pins are asynchronous.
// Notes: Queue 1 preempts queue 2; pause bits split queues into subqueues.
`timescale 1ns/1ps
`default_nettype none

module adc_queue_scheduler (
    // Clock, reset and clock enable.
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // Command table write port.
    input wire logic tbl_we,
    input wire logic [adc_queue_pkg::IDX_W-1:0] tbl_addr,
    input wire adc_queue_pkg::conversion_command_entry_t tbl_data,
    // Queue configuration.
    input wire logic [adc_queue_pkg::PTR_W-1:0] q2_begin,
    input wire adc_queue_pkg::queue_mode_t queue1_mode,
    input wire adc_queue_pkg::queue_mode_t queue2_mode,
    input wire logic resume_sel,
    // Trigger sources.
    input wire logic queue1_trigger_pin,
    input wire logic queue2_trigger_pin,
    input wire logic sw_trigger1,
    input wire logic sw_trigger2,
    input wire logic timer_expired,
    // Converter core.
    output logic conv_req,
    output logic [adc_queue_pkg::CHAN_W-1:0] conv_chan,
    output logic conv_abort,
    input wire logic conv_done,
    input wire logic [adc_queue_pkg::RES_W-1:0] conv_result,
    // Result table write.
    output logic res_we,
    output logic [adc_queue_pkg::IDX_W-1:0] res_addr,
    output logic [adc_queue_pkg::RES_W-1:0] res_data,
    // Status.
    input wire adc_queue_pkg::queue_flags_t flag1_clr,
    input wire adc_queue_pkg::queue_flags_t flag2_clr,
    output adc_queue_pkg::queue_flags_t flag1,
    output adc_queue_pkg::queue_flags_t flag2,
    output logic [adc_queue_pkg::STATE_W-1:0] queue_state_field
);

    ////////////////////////////////////////////////////////////////////////////
    // End-of-queue test shared by both queues: past its limit, past the table,
    // or carrying the end code.
    function automatic logic at_end(input logic [adc_queue_pkg::PTR_W-1:0] ptr,
                                    input logic [adc_queue_pkg::PTR_W-1:0] limit,
                                    input logic [adc_queue_pkg::CHAN_W-1:0] chan);
        at_end = (ptr >= limit) || (ptr >= adc_queue_pkg::TABLE_END) ||
                 (chan == adc_queue_pkg::END_OF_QUEUE_CODE);
    endfunction

    adc_queue_pkg::conversion_command_entry_t table_q [adc_queue_pkg::TABLE_DEPTH];
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] pin_prev_q;
    logic [1:0] pin_rise;
    adc_queue_pkg::engine_state_t eng_q;
    adc_queue_pkg::queue_status_t q1_st_q;
    adc_queue_pkg::queue_status_t q2_st_q;
    logic pend1_q;
    logic pend2_q;
    logic owner2_q;
    logic pause_seen_q;
    logic conv_pause_q;
    logic [adc_queue_pkg::PTR_W-1:0] ptr1_q;
    logic [adc_queue_pkg::PTR_W-1:0] ptr2_q;
    logic [1:0] end_evt_q;
    logic [1:0] hold_evt_q;
    logic [1:0] loop_evt_q;
    logic trig1;
    logic trig2;
    logic busy1;
    logic busy2;
    logic take1;
    logic take2;
    logic ovr1;
    logic ovr2;
    logic [adc_queue_pkg::PTR_W-1:0] cur_ptr;
    logic [adc_queue_pkg::PTR_W-1:0] cur_limit;
    adc_queue_pkg::conversion_command_entry_t cur_entry;
    logic cur_end;
    logic cur_auto;
    logic [1:0] q1_code;
    logic [1:0] q2_code;

    ////////////////////////////////////////////////////////////////////////////
    // Command table storage; software may rewrite it at any time.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < adc_queue_pkg::TABLE_DEPTH; i++) begin
                table_q[i] <= '0;
            end
        end else if (ce && tbl_we) begin
            table_q[tbl_addr] <= tbl_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger pins pass two flip-flops, then a third stage finds the rising edge.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
            pin_prev_q <= 2'h0;
        end else if (ce) begin
            pin_s1_q <= {queue2_trigger_pin, queue1_trigger_pin};
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    assign pin_rise = pin_s2_q & ~pin_prev_q;

    // Trigger sources per queue; only queue 2 hears the timer.
    assign trig1 = (queue1_mode.ext_rise_en & pin_rise[0]) | sw_trigger1 | loop_evt_q[0];
    assign trig2 = (queue2_mode.ext_rise_en & pin_rise[1]) | sw_trigger2 | timer_expired |
                   loop_evt_q[1];

    // A queue is busy from trigger acceptance until it pauses or completes; a
    // trigger while busy is dropped and only counted as an overrun.
    assign busy1 = pend1_q || (q1_st_q == adc_queue_pkg::QST_ACTIVE);
    assign busy2 = pend2_q || (q2_st_q == adc_queue_pkg::QST_ACTIVE) ||
                   (q2_st_q == adc_queue_pkg::QST_SUSP);
    assign take1 = trig1 & ~busy1;
    assign take2 = trig2 & ~busy2;
    assign ovr1 = trig1 & busy1;
    assign ovr2 = trig2 & busy2;

    // The entry under the owning queue's pointer; queue 1 stops where queue 2 begins.
    assign cur_ptr = owner2_q ? ptr2_q : ptr1_q;
    assign cur_limit = owner2_q ? adc_queue_pkg::TABLE_END : q2_begin;
    assign cur_entry = table_q[cur_ptr[adc_queue_pkg::IDX_W-1:0]];
    assign cur_end = at_end(cur_ptr, cur_limit, cur_entry.chan);
    assign cur_auto = owner2_q ? (queue2_mode.continuous & queue2_mode.auto_loop) :
                      (queue1_mode.continuous & queue1_mode.auto_loop);

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration and sequencing. Accepted triggers become pending first, so a
    // queue 2 start shows at least one cycle of the pending code before it runs.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            eng_q <= adc_queue_pkg::ENG_IDLE;
            q1_st_q <= adc_queue_pkg::QST_IDLE;
            q2_st_q <= adc_queue_pkg::QST_IDLE;
            pend1_q <= 1'b0;
            pend2_q <= 1'b0;
            owner2_q <= 1'b0;
            pause_seen_q <= 1'b0;
            conv_pause_q <= 1'b0;
            ptr1_q <= adc_queue_pkg::Q1_BEGIN;
            ptr2_q <= adc_queue_pkg::Q1_BEGIN;
            conv_req <= 1'b0;
            conv_chan <= '0;
            conv_abort <= 1'b0;
            res_we <= 1'b0;
            res_addr <= '0;
            res_data <= '0;
            end_evt_q <= 2'h0;
            hold_evt_q <= 2'h0;
            loop_evt_q <= 2'h0;
        end else if (ce) begin
            conv_abort <= 1'b0;
            res_we <= 1'b0;
            end_evt_q <= 2'h0;
            hold_evt_q <= 2'h0;
            loop_evt_q <= 2'h0;
            if (take1) begin
                pend1_q <= 1'b1;
            end
            if (take2) begin
                pend2_q <= 1'b1;
            end
            if (owner2_q && pend1_q && (eng_q != adc_queue_pkg::ENG_IDLE)) begin
                // Queue 1 preempts at once so its latency never depends on queue 2.
                // Limitation: a preempt in the fetch step right after a pause entry
                // loses that pause, so a resumed queue 2 runs on into its next subqueue.
                conv_abort <= (eng_q == adc_queue_pkg::ENG_CONV);
                conv_req <= 1'b0;
                q2_st_q <= adc_queue_pkg::QST_SUSP;
                if (!resume_sel) begin
                    ptr2_q <= q2_begin;
                end
                pend1_q <= 1'b0;
                q1_st_q <= adc_queue_pkg::QST_ACTIVE;
                if (q1_st_q == adc_queue_pkg::QST_IDLE) begin
                    ptr1_q <= adc_queue_pkg::Q1_BEGIN;
                end
                owner2_q <= 1'b0;
                pause_seen_q <= 1'b0;
                eng_q <= adc_queue_pkg::ENG_FETCH;
            end else begin
                case (eng_q)
                    adc_queue_pkg::ENG_IDLE: begin
                        pause_seen_q <= 1'b0;
                        if (pend1_q) begin
                            pend1_q <= 1'b0;
                            q1_st_q <= adc_queue_pkg::QST_ACTIVE;
                            if (q1_st_q == adc_queue_pkg::QST_IDLE) begin
                                ptr1_q <= adc_queue_pkg::Q1_BEGIN;
                            end
                            owner2_q <= 1'b0;
                            eng_q <= adc_queue_pkg::ENG_FETCH;
                        end else if (q2_st_q == adc_queue_pkg::QST_SUSP) begin
                            q2_st_q <= adc_queue_pkg::QST_ACTIVE;
                            owner2_q <= 1'b1;
                            eng_q <= adc_queue_pkg::ENG_FETCH;
                        end else if (pend2_q) begin
                            pend2_q <= 1'b0;
                            q2_st_q <= adc_queue_pkg::QST_ACTIVE;
                            if (q2_st_q == adc_queue_pkg::QST_IDLE) begin
                                ptr2_q <= q2_begin;
                            end
                            owner2_q <= 1'b1;
                            eng_q <= adc_queue_pkg::ENG_FETCH;
                        end
                    end
                    adc_queue_pkg::ENG_FETCH: begin
                        if (cur_end) begin
                            // End wins over a pause in the same entry: no conversion.
                            end_evt_q <= owner2_q ? 2'h2 : 2'h1;
                            loop_evt_q <= cur_auto ? (owner2_q ? 2'h2 : 2'h1) : 2'h0;
                            if (owner2_q) begin
                                q2_st_q <= adc_queue_pkg::QST_IDLE;
                            end else begin
                                q1_st_q <= adc_queue_pkg::QST_IDLE;
                            end
                            eng_q <= adc_queue_pkg::ENG_IDLE;
                        end else if (pause_seen_q) begin
                            if (owner2_q) begin
                                q2_st_q <= adc_queue_pkg::QST_PAUSED;
                            end else begin
                                q1_st_q <= adc_queue_pkg::QST_PAUSED;
                            end
                            eng_q <= adc_queue_pkg::ENG_IDLE;
                        end else begin
                            conv_req <= 1'b1;
                            conv_chan <= cur_entry.chan;
                            conv_pause_q <= cur_entry.pause;
                            res_addr <= cur_ptr[adc_queue_pkg::IDX_W-1:0];
                            eng_q <= adc_queue_pkg::ENG_CONV;
                        end
                    end
                    adc_queue_pkg::ENG_CONV: begin
                        if (conv_done) begin
                            conv_req <= 1'b0;
                            res_we <= 1'b1;
                            res_data <= conv_result;
                            if (owner2_q) begin
                                ptr2_q <= ptr2_q + adc_queue_pkg::PTR_STEP;
                            end else begin
                                ptr1_q <= ptr1_q + adc_queue_pkg::PTR_STEP;
                            end
                            if (conv_pause_q) begin
                                // Look at the next entry first: an end there gives
                                // completion and idle rather than paused.
                                hold_evt_q <= owner2_q ? 2'h2 : 2'h1;
                                pause_seen_q <= 1'b1;
                            end
                            eng_q <= adc_queue_pkg::ENG_FETCH;
                        end
                    end
                    default: begin
                        eng_q <= adc_queue_pkg::ENG_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags; a set in the same cycle as its clear wins. Overruns come
    // straight from the trigger terms, so they show one cycle after the trigger.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flag1 <= '0;
            flag2 <= '0;
        end else if (ce) begin
            flag1 <= (flag1 & ~flag1_clr) | {end_evt_q[0], hold_evt_q[0], ovr1};
            flag2 <= (flag2 & ~flag2_clr) | {end_evt_q[1], hold_evt_q[1], ovr2};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Queue state codes; pending with queue 1 not active lasts one cycle only.
    always_comb begin
        q1_code = adc_queue_pkg::ST1_IDLE;
        if (q1_st_q == adc_queue_pkg::QST_ACTIVE) begin
            q1_code = adc_queue_pkg::ST1_ACTIVE;
        end else if (q1_st_q == adc_queue_pkg::QST_PAUSED) begin
            q1_code = adc_queue_pkg::ST1_PAUSED;
        end
        q2_code = adc_queue_pkg::ST2_IDLE;
        if (pend2_q) begin
            q2_code = adc_queue_pkg::ST2_PENDING;
        end else if ((q2_st_q == adc_queue_pkg::QST_ACTIVE) ||
                     (q2_st_q == adc_queue_pkg::QST_SUSP)) begin
            q2_code = adc_queue_pkg::ST2_RUN_OR_SUSP;
        end else if (q2_st_q == adc_queue_pkg::QST_PAUSED) begin
            q2_code = adc_queue_pkg::ST2_PAUSED;
        end
    end

    // Registered so the field never glitches on the way out.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            queue_state_field <= '0;
        end else if (ce) begin
            queue_state_field <= {q1_code, q2_code};
        end
    end

endmodule // adc_queue_scheduler

`default_nettype wire

// ===== tb/conv_core_model.sv
// Purpose: Behavioural converter core that answers the scheduler's requests.
// Assumes: One request at a time; the latency input sets the answer delay.
// Notes: Between answers the result lines toggle every cycle, so no stale value survives.
`timescale 1ns/1ps
`default_nettype none

module conv_core_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_b,
    // Request from the scheduler.
    input wire logic conv_req,
    input wire logic [adc_queue_pkg::CHAN_W-1:0] conv_chan,
    input wire logic conv_abort,
    input wire logic [7:0] lat,
    // Answer to the scheduler.
    output logic conv_done,
    output logic [adc_queue_pkg::RES_W-1:0] conv_result
);
    logic [7:0] cnt_q;

    // Count request cycles; a dropped request or a delivered answer restarts the count.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 8'h00;
            conv_done <= 1'b0;
            conv_result <= 10'h000;
        end else if (conv_req && !conv_done && !conv_abort && cnt_q == lat) begin
            cnt_q <= 8'h00;
            conv_done <= 1'b1;
            conv_result <= {4'h9, conv_chan};
        end else begin
            cnt_q <= (conv_req && !conv_done) ? cnt_q + 8'h01 : 8'h00;
            conv_done <= 1'b0;
            conv_result <= ~conv_result;
        end
    end
endmodule // conv_core_model

`default_nettype wire

// ===== tb/adc_queue_sva.sv
// Purpose: Concurrent checks on the converter scheduler's ports.
// Assumes: Single clock mclk; rst_b low clears all state.
// Notes: Bound to every scheduler instance below the module.
`timescale 1ns/1ps
`default_nettype none

module adc_queue_sva (
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // Software triggers.
    input wire logic sw_trigger1,
    input wire logic sw_trigger2,
    // Converter and result table.
    input wire logic conv_req,
    input wire logic [adc_queue_pkg::CHAN_W-1:0] conv_chan,
    input wire logic conv_abort,
    input wire logic conv_done,
    input wire logic [adc_queue_pkg::RES_W-1:0] conv_result,
    input wire logic res_we,
    input wire logic [adc_queue_pkg::RES_W-1:0] res_data,
    // Status.
    input wire adc_queue_pkg::queue_flags_t flag1_clr,
    input wire adc_queue_pkg::queue_flags_t flag1,
    input wire adc_queue_pkg::queue_flags_t flag2,
    input wire logic [adc_queue_pkg::STATE_W-1:0] queue_state_field
);
    logic [3:0] qstate;

    // Short alias keeps the state comparisons readable.
    assign qstate = queue_state_field;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    // A queue 2 conversion in flight with queue 1 idle meets a queue 1 trigger.
    sequence q1_hits_q2;
        ce && conv_req && !conv_done && qstate == 4'h2 && sw_trigger1 ##1 !conv_done;
    endsequence
    // The abort pulse, then queue 1 active with queue 2 suspended.
    sequence abort_then_susp;
        conv_abort ##[0:2] qstate == 4'ha;
    endsequence

    preempt_abort_a: assert property (
        q1_hits_q2 |-> ##[1:3] abort_then_susp)
        else $error("Queue 1 trigger did not abort queue 2.");
    done_write_a: assert property (
        ce && conv_req && conv_done |=> res_we && !conv_req && res_data == $past(conv_result))
        else $error("Finished conversion not written back.");
    abort_drop_a: assert property (
        ce && conv_abort |-> !conv_req ##1 !conv_abort)
        else $error("Abort left a request standing.");
    chan_hold_a: assert property (
        conv_req && $past(conv_req) |-> $stable(conv_chan))
        else $error("Channel changed during a request.");
    end_skip_a: assert property (
        conv_req |-> conv_chan != adc_queue_pkg::END_OF_QUEUE_CODE)
        else $error("End-of-queue entry was converted.");
    transient_brief_a: assert property (
        ce && (qstate == 4'h3 || qstate == 4'h7) |=> !(qstate == 4'h3 || qstate == 4'h7))
        else $error("Transient state code persisted.");
    pend_overrun_a: assert property (
        ce && sw_trigger2 && qstate[1:0] == adc_queue_pkg::ST2_PENDING |=>
            flag2.trigger_overrun_flag)
        else $error("Trigger while pending did not flag overrun.");
    susp_overrun_a: assert property (
        ce && sw_trigger2 && qstate == 4'ha |=> flag2.trigger_overrun_flag)
        else $error("Trigger while suspended did not flag overrun.");
    comp_sticky_a: assert property (
        ce && flag1.completion_flag && !flag1_clr.completion_flag |=> flag1.completion_flag)
        else $error("Completion flag dropped without a clear.");
endmodule // adc_queue_sva

bind adc_queue_scheduler adc_queue_sva chk_i (.mclk, .rst_b, .ce, .sw_trigger1,
    .sw_trigger2, .conv_req, .conv_chan, .conv_abort, .conv_done, .conv_result, .res_we,
    .res_data, .flag1_clr, .flag1, .flag2, .queue_state_field);

`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the two-queue converter scheduler.
// Assumes: The core model answers every request that is not aborted after a set latency.
// Notes: Inputs change on the falling edge; results are checked per table entry.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic mclk, rst_b, tbl_we, resume_sel, timer_expired;
    logic queue1_trigger_pin, queue2_trigger_pin, sw_trigger1, sw_trigger2;
    logic conv_req, conv_abort, conv_done, res_we;
    logic [adc_queue_pkg::IDX_W-1:0] tbl_addr, res_addr;
    logic [adc_queue_pkg::CHAN_W-1:0] conv_chan;
    logic [adc_queue_pkg::RES_W-1:0] conv_result, res_data;
    logic [adc_queue_pkg::PTR_W-1:0] q2_begin;
    logic [adc_queue_pkg::STATE_W-1:0] qstate;
    adc_queue_pkg::conversion_command_entry_t tbl_data;
    adc_queue_pkg::queue_mode_t queue1_mode, queue2_mode;
    adc_queue_pkg::queue_flags_t flag1, flag2, flag1_clr, flag2_clr;
    logic [7:0] lat;
    int err_total, checked, aborts, writes;

    adc_queue_scheduler DUT (.mclk, .rst_b, .ce(1'b1), .tbl_we, .tbl_addr, .tbl_data,
        .q2_begin, .queue1_mode, .queue2_mode, .resume_sel, .queue1_trigger_pin,
        .queue2_trigger_pin, .sw_trigger1, .sw_trigger2, .timer_expired, .conv_req,
        .conv_chan, .conv_abort, .conv_done, .conv_result, .res_we, .res_addr, .res_data,
        .flag1_clr, .flag2_clr, .flag1, .flag2, .queue_state_field(qstate));
    conv_core_model core (.mclk, .rst_b, .conv_req, .conv_chan, .conv_abort, .lat,
        .conv_done, .conv_result);

    ////////////////////////////////////////////////////////////////////////////
    // Free-running 50 MHz clock.
    always #10 mclk = ~mclk;

    // Count one-cycle pulses that a sampled wait could otherwise miss.
    always @(negedge mclk) begin
        aborts += int'(conv_abort === 1'b1);
        writes += int'(res_we === 1'b1);
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // One-cycle pulse on {timer, software 2, software 1}.
    task automatic trig(input logic [2:0] which);
        {timer_expired, sw_trigger2, sw_trigger1} = which;
        step(1);
        {timer_expired, sw_trigger2, sw_trigger1} = 3'h0;
    endtask

    task automatic wr(input int idx, input logic p, input int ch);
        tbl_we = 1'b1;
        tbl_addr = idx[5:0];
        tbl_data = '{pause: p, chan: ch[5:0]};
        step(1);
        tbl_we = 1'b0;
        step(1);
    endtask

    // Waits, bounded, for the next result write and checks slot and value.
    task automatic wait_res(input int a, input int c);
        int n;
        n = 0;
        while (res_we !== 1'b1 && n < 300) begin
            step(1);
            n++;
        end
        chk(16'(res_we), 16'h0001);
        chk(16'(res_addr), 16'(a[5:0]));
        chk(16'(res_data), {6'h00, 4'h9, c[5:0]});
        step(1);
    endtask

    task automatic wait_state(input logic [3:0] v);
        int n;
        n = 0;
        while (qstate !== v && n < 400) begin
            step(1);
            n++;
        end
        chk(16'(qstate), 16'(v));
    endtask

    task automatic clr(input int t);
        flag1_clr = 3'h7;
        flag2_clr = 3'h7;
        step(1);
        flag1_clr = 3'h0;
        flag2_clr = 3'h0;
        $display("test %0d finished", t);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog sized well above the several hundred cycles the tests need.
    initial begin
        repeat (30000) @(posedge mclk);
        err_total++;
        print_verdict();
    end

    // Main sequence: queue 1 runs 0..3 with a pause at 1, queue 2 runs 60..63.
    initial begin
        int w0;
        {mclk, rst_b, tbl_we, resume_sel, timer_expired} = 5'h00;
        {queue1_trigger_pin, queue2_trigger_pin, sw_trigger1, sw_trigger2} = 4'h0;
        {tbl_addr, tbl_data, queue1_mode, queue2_mode} = '0;
        {flag1_clr, flag2_clr, lat, q2_begin} = {6'h00, 8'h10, 7'h3c};
        step(2);
        rst_b = 1'b1;
        step(1);
        chk(16'({flag1, flag2, qstate}), 16'h0000);
        wr(0, 1'b0, 5);
        wr(1, 1'b1, 12);
        wr(2, 1'b0, 20);
        wr(3, 1'b0, 63);
        wr(60, 1'b0, 9);
        wr(61, 1'b0, 10);
        wr(62, 1'b0, 11);
        wr(63, 1'b0, 63);
        // Pause, overrun during a subqueue, then continue at the next entry.
        trig(3'h1);
        step(6);
        trig(3'h1);
        wait_res(0, 5);
        wait_res(1, 12);
        wait_state(4'h4);
        chk(16'(flag1), 16'h0003);
        trig(3'h1);
        wait_res(2, 20);
        wait_state(4'h0);
        chk(16'(flag1), 16'h0007);
        clr(1);
        // Same-cycle triggers; queue 2 waits for queue 1 to pause.
        trig(3'h3);
        wait_state(4'hb);
        trig(3'h2);
        wait_res(0, 5);
        wait_res(1, 12);
        wait_res(60, 9);
        wait_res(61, 10);
        wait_res(62, 11);
        wait_state(4'h4);
        chk(16'({flag1, flag2}), 16'h0015);
        trig(3'h1);
        wait_res(2, 20);
        wait_state(4'h0);
        clr(2);
        // Queue 1 preempts queue 2 under both restart selections.
        lat = 8'h1e;
        for (int i = 0; i < 2; i++) begin
            resume_sel = i[0];
            trig(3'h2);
            wait_res(60, 9);
            step(6);
            trig(3'h1);
            wait_state(4'ha);
            trig(3'h2);
            wait_res(i ? 2 : 0, i ? 20 : 5);
            if (i == 0)
                wait_res(1, 12);
            wait_res(i ? 61 : 60, i ? 10 : 9);
            wait_state(i ? 4'h0 : 4'h4);
            chk(16'(aborts), 16'(i + 1));
            chk(16'(flag2), 16'h0005);
            clr(3 + i);
        end
        // Pin edges for queue 1, timer for a continuous queue 2.
        lat = 8'h04;
        queue1_mode = 3'h4;
        queue2_mode = 3'h2;
        queue1_trigger_pin = 1'b1;
        wait_res(0, 5);
        wait_res(1, 12);
        wait_state(4'h4);
        queue1_trigger_pin = 1'b0;
        step(4);
        queue1_trigger_pin = 1'b1;
        wait_res(2, 20);
        wait_state(4'h0);
        trig(3'h4);
        wait_res(60, 9);
        wait_state(4'h0);
        trig(3'h4);
        wait_res(60, 9);
        wait_state(4'h0);
        // Loop completion retriggers queue 2 once; auto loop is dropped on the way.
        queue2_mode = 3'h3;
        trig(3'h4);
        for (int k = 0; k < 6; k++) begin
            wait_res(60 + k % 3, 9 + k % 3);
            queue2_mode[0] = (k < 3);
        end
        wait_state(4'h0);
        clr(5);
        // One queue only: queue 2 begins past the table and ends at once.
        q2_begin = 7'h40;
        w0 = writes;
        trig(3'h2);
        step(10);
        chk(16'(writes - w0), 16'h0000);
        chk(16'(flag2), 16'h0004);
        clr(6);
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
